// ---- ptsp_pkg.sv ----
// constants and types for the precision time port state block
package ptsp_pkg;
    localparam int NPORTS = 2;
    localparam int AW = 8;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PS_INIT = 4'h0,
        PS_FAULTY = 4'h1,
        PS_DISABLED = 4'h2,
        PS_LISTENING = 4'h3,
        PS_PREMASTER = 4'h4,
        PS_MASTER = 4'h5,
        PS_PASSIVE = 4'h6,
        PS_UNCAL = 4'h7,
        PS_SLAVE = 4'h8,
        PS_GRANDMASTER = 4'h9,
        PS_ERROR = 4'hA
    } ptsp_port_state_t;

    typedef enum logic [1:0] {
        SV_UNLOCKED = 2'h0,
        SV_SYNCING = 2'h1,
        SV_LOCKED = 2'h2,
        SV_NA = 2'h3
    } ptsp_servo_t;

    typedef enum logic [1:0] {
        MD_OFF = 2'h0,
        MD_AUTO = 2'h1,
        MD_SLAVE = 2'h2
    } ptsp_mode_t;

    // message classes seen by the gate
    typedef enum logic [2:0] {
        MC_EVENT = 3'h0,
        MC_ANNOUNCE = 3'h1,
        MC_PDELAY = 3'h2,
        MC_SIGNALING = 3'h3,
        MC_MGMT_RESP = 3'h4,
        MC_MGMT = 3'h5
    } ptsp_msg_t;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [AW-1:0] OFS_MAC_LO = 8'h08;
    localparam logic [AW-1:0] OFS_MAC_HI = 8'h0C;
    localparam logic [AW-1:0] OFS_BMI_LO = 8'h10;
    localparam logic [AW-1:0] OFS_BMI_HI = 8'h14;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EN_LSB = 4;
    localparam int ST_DEV_LSB = 0;
    localparam int ST_SERVO_LSB = 4;
    localparam int ST_PORT_LSB = 8;

    localparam logic [1:0] RST_MODE = 2'h1;
    localparam logic [NPORTS-1:0] RST_PORT_EN = 2'h3;
    localparam logic [47:0] RST_MAC = 48'h0;
    localparam logic [15:0] EUI_FILL = 16'hFFFE;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ptsp_pkg

// ---- ptsp_msg_gate.sv ----
// which message classes a port may send or must drop in a state
`timescale 1ns/1ps
module ptsp_msg_gate
    import ptsp_pkg::*;
(
    input wire ptsp_port_state_t state, // port state code
    input wire ptsp_msg_t cls,          // message class
    output logic tx_ok,                 // class may be sent
    output logic rx_ok                  // received class is kept
);
    always_comb begin
        unique case (state)
            PS_INIT, PS_DISABLED, PS_ERROR: tx_ok = 1'b0;
            PS_FAULTY: tx_ok = (cls == MC_MGMT_RESP);
            PS_LISTENING, PS_PASSIVE: begin
                tx_ok = (cls == MC_PDELAY) || (cls == MC_SIGNALING) ||
                        (cls == MC_MGMT_RESP);
            end
            PS_PREMASTER: begin
                tx_ok = (cls == MC_PDELAY) || (cls == MC_SIGNALING) ||
                        (cls == MC_MGMT_RESP) || (cls == MC_MGMT);
            end
            default: tx_ok = 1'b1;
        endcase
        rx_ok = (state != PS_DISABLED) || (cls == MC_MGMT) ||
                (cls == MC_MGMT_RESP);
    end
endmodule : ptsp_msg_gate

// ---- ptsp_port_state.sv ----
// port state tracking, servo lock report, message gating, axi-lite regs
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - report port state as one of eleven codes, updated as protocol moves
// - initializing port sets itself up and sends no messages
// - one port initializing holds every port initializing
// - faulty port sends only management answers; fault stays on its port
// - fault that cannot be confined puts every port faulty; here a port held initializing or disabled keeps that state
// - disabled port sends nothing, drops all but management on receive
// - listening waits for timeout or announce; sends pdelay/signal/answers
// - premaster acts as master but sends only pdelay, signal, management
// - passive sends only pdelay, signaling and management answers
// - selected master leads through transient uncalibrated state
// - slave synchronises to the master; master acts as master
// - grandmaster only in automatic mode after another master was seen
// - error status whenever any port reports an error
// - report servo state: unlocked, synchronizing, locked, not applicable
// - best master identity is mac upper half, fffe, mac lower half
// - mode off disables, automatic lets it choose, slave is slave-only
module ptsp_port_state
    import ptsp_pkg::*;
(
    input wire logic aclk,                        // 25 MHz clock
    input wire logic aresetn,                     // sync reset, low
    input wire logic [AW-1:0] awaddr,             // write address
    input wire logic awvalid,                     // write address valid
    output logic awready,                         // write address ready
    input wire logic [31:0] wdata,                // write data
    input wire logic [3:0] wstrb,                 // write strobes
    input wire logic wvalid,                      // write data valid
    output logic wready,                          // write data ready
    output logic [1:0] bresp,                     // write response
    output logic bvalid,                          // write response valid
    input wire logic bready,                      // write response ready
    input wire logic [AW-1:0] araddr,             // read address
    input wire logic arvalid,                     // read address valid
    output logic arready,                         // read address ready
    output logic [31:0] rdata,                    // read data
    output logic [1:0] rresp,                     // read response
    output logic rvalid,                          // read data valid
    input wire logic rready,                      // read data ready
    input wire logic init_done,                   // data sets set up
    input wire logic [NPORTS-1:0] port_fault,     // fault on a port
    input wire logic fault_unconfined,            // fault not isolable
    input wire logic [NPORTS-1:0] port_error,     // port error condition
    input wire logic [NPORTS-1:0] announce_rx,    // master announce kept
    input wire logic [NPORTS-1:0] announce_tmo,   // announce timeout
    input wire logic [NPORTS-1:0] qual_tmo,       // qualification timeout
    input wire logic [NPORTS-1:0] bmc_passive,    // selection says passive
    input wire logic servo_converging,            // servo converging
    input wire logic servo_locked,                // servo tracking master
    input wire logic [47:0] master_mac,           // mac of remote master
    input wire logic tx_valid,                    // message wants to go
    input wire logic tx_port,                     // its port
    input wire ptsp_msg_t tx_class,               // its class
    output logic tx_grant,                        // it may go
    input wire logic rx_valid,                    // message received
    input wire logic rx_port,                     // its port
    input wire ptsp_msg_t rx_class,               // its class
    output logic rx_accept,                       // keep it, else drop
    output ptsp_port_state_t port_sync_state,     // device state code
    output ptsp_servo_t servo_lock_state,         // servo code
    output logic [63:0] best_master_identity      // eui-64 of best master
);
    default clocking d_clk @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic ptsp_port_state_t next_port(
        input ptsp_port_state_t cur,
        input ptsp_mode_t mode,
        input logic en, input logic hold, input logic fault,
        input logic ann, input logic ato, input logic qto,
        input logic pas, input logic lock, input logic seen);
        ptsp_port_state_t n;
        n = cur;
        if (hold) begin
            n = PS_INIT;
        end else if (!(mode == MD_AUTO || mode == MD_SLAVE) || !en) begin
            n = PS_DISABLED;
        end else if (fault) begin
            n = PS_FAULTY;
        end else begin
            unique case (cur)
                PS_INIT, PS_FAULTY, PS_DISABLED: n = PS_LISTENING;
                PS_LISTENING: begin
                    if (ann) n = PS_UNCAL;
                    else if (ato && mode == MD_AUTO) n = PS_PREMASTER;
                end
                PS_PREMASTER: begin
                    if (ann) n = PS_UNCAL;
                    else if (qto) n = (seen && mode == MD_AUTO) ?
                        PS_GRANDMASTER : PS_MASTER;
                end
                PS_MASTER, PS_GRANDMASTER: begin
                    if (ann) n = PS_UNCAL;
                    else if (pas) n = PS_PASSIVE;
                end
                PS_PASSIVE: begin
                    if (ann) n = PS_UNCAL;
                    else if (ato) begin
                        n = (mode == MD_AUTO) ? PS_PREMASTER : PS_LISTENING;
                    end
                end
                PS_UNCAL: begin
                    if (ato) n = PS_LISTENING;
                    else if (lock) n = PS_SLAVE;
                end
                PS_SLAVE: begin
                    if (ato) n = PS_LISTENING;
                end
                default: n = PS_INIT;
            endcase
        end
        return n;
    endfunction : next_port

    function automatic logic mapped(input logic [AW-1:0] a);
        return a == OFS_CTRL || a == OFS_STATUS || a == OFS_MAC_LO ||
               a == OFS_MAC_HI || a == OFS_BMI_LO || a == OFS_BMI_HI;
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    ptsp_mode_t mode_r;
    logic [NPORTS-1:0] port_en_r;
    logic [47:0] mac_r;
    logic aw_hold_r, w_hold_r;
    logic [AW-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [31:0] ctrl_nxt, mac_hi_nxt;
    ptsp_port_state_t port_r [NPORTS];
    logic seen_master_r;

    assign awready = !aw_hold_r && !bvalid;
    assign wready = !w_hold_r && !bvalid;
    assign arready = !rvalid;
    assign ctrl_nxt = merge({26'h0, port_en_r, 2'h0, mode_r}, wdata_r,
                            wstrb_r);
    assign mac_hi_nxt = merge({16'h0, mac_r[47:32]}, wdata_r, wstrb_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (aw_hold_r && w_hold_r) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // a reserved mode code falls back to off rather than a guess
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= ptsp_mode_t'(RST_MODE);
            port_en_r <= RST_PORT_EN;
            mac_r <= RST_MAC;
        end else if (aw_hold_r && w_hold_r) begin
            unique case (awaddr_r)
                OFS_CTRL: begin
                    mode_r <= (ctrl_nxt[CTRL_MODE_LSB +: 2] == 2'h3) ?
                        MD_OFF : ptsp_mode_t'(ctrl_nxt[CTRL_MODE_LSB +: 2]);
                    port_en_r <= ctrl_nxt[CTRL_EN_LSB +: NPORTS];
                end
                OFS_MAC_LO: mac_r[31:0] <= merge(mac_r[31:0], wdata_r,
                                                 wstrb_r);
                OFS_MAC_HI: mac_r[47:32] <= mac_hi_nxt[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFS_CTRL: rdata <= {26'h0, port_en_r, 2'h0, mode_r};
                OFS_STATUS: rdata <= {16'h0, port_r[1], port_r[0],
                                      2'h0, servo_lock_state,
                                      port_sync_state};
                OFS_MAC_LO: rdata <= mac_r[31:0];
                OFS_MAC_HI: rdata <= {16'h0, mac_r[47:32]};
                OFS_BMI_LO: rdata <= best_master_identity[31:0];
                OFS_BMI_HI: rdata <= best_master_identity[63:32];
                default: rdata <= '0;
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // port state machines
    // ------------------------------------------------------------
    logic [NPORTS-1:0] is_init, is_sync;
    logic hold_init;
    logic mode_on;

    assign mode_on = (mode_r == MD_AUTO) || (mode_r == MD_SLAVE);
    // all ports leave initializing together or not at all
    assign hold_init = !init_done || ((|is_init) && !(&is_init));

    generate
        for (genvar p = 0; p < NPORTS; p++) begin : g_port
            assign is_init[p] = (port_r[p] == PS_INIT);
            assign is_sync[p] = (port_r[p] == PS_UNCAL) ||
                                (port_r[p] == PS_SLAVE);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    port_r[p] <= PS_INIT;
                end else begin
                    // fault input of one port only moves that port
                    port_r[p] <= next_port(port_r[p], mode_r,
                        port_en_r[p], hold_init,
                        port_fault[p] || fault_unconfined,
                        announce_rx[p], announce_tmo[p], qual_tmo[p],
                        bmc_passive[p], servo_locked,
                        seen_master_r);
                end
            end
        end
    endgenerate

    // a remote master has been followed once; cleared when turned off
    always_ff @(posedge aclk) begin
        if (!aresetn || !mode_on) begin
            seen_master_r <= 1'b0;
        end else if (|is_sync) begin
            seen_master_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // reported status
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_sync_state <= PS_INIT;
            servo_lock_state <= SV_NA;
            best_master_identity <= '0;
        end else begin
            port_sync_state <= (|port_error) ? PS_ERROR :
                next_port(port_r[0], mode_r, port_en_r[0], hold_init,
                    port_fault[0] || fault_unconfined, announce_rx[0],
                    announce_tmo[0], qual_tmo[0], bmc_passive[0],
                    servo_locked, seen_master_r);
            if (!(|is_sync)) servo_lock_state <= SV_NA;
            else if (servo_locked) servo_lock_state <= SV_LOCKED;
            else if (servo_converging) servo_lock_state <= SV_SYNCING;
            else servo_lock_state <= SV_UNLOCKED;
            best_master_identity <= (|is_sync) ?
                {master_mac[47:24], EUI_FILL, master_mac[23:0]} :
                {mac_r[47:24], EUI_FILL, mac_r[23:0]};
        end
    end

    // ------------------------------------------------------------
    // message gating
    // ------------------------------------------------------------
    logic tx_ok, rx_ok;

    ptsp_msg_gate u_tx_gate (
        .state(port_r[tx_port]),
        .cls(tx_class),
        .tx_ok(tx_ok),
        .rx_ok()
    );
    ptsp_msg_gate u_rx_gate (
        .state(port_r[rx_port]),
        .cls(rx_class),
        .tx_ok(),
        .rx_ok(rx_ok)
    );
    assign tx_grant = tx_valid && tx_ok;
    assign rx_accept = rx_valid && rx_ok;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_init_no_tx: assert property (port_r[tx_port] == PS_INIT
        |-> !tx_grant)
        else $error("message sent while initializing");
    a_init_all: assert property (!init_done |=> &is_init)
        else $error("ports not all initializing");
    a_fault_all: assert property (fault_unconfined && mode_on &&
        init_done && !(|is_init) && (&port_en_r)
        |=> port_r[0] == PS_FAULTY && port_r[1] == PS_FAULTY)
        else $error("unconfined fault left a port out");
    a_faulty_tx: assert property (port_r[tx_port] == PS_FAULTY &&
        tx_class != MC_MGMT_RESP |-> !tx_grant)
        else $error("faulty port sent a non-answer");
    a_disabled_rx: assert property (port_r[rx_port] == PS_DISABLED &&
        rx_class inside {MC_EVENT, MC_ANNOUNCE, MC_PDELAY, MC_SIGNALING}
        |-> !rx_accept)
        else $error("disabled port kept a message");
    a_premaster_tx: assert property (
        port_r[tx_port] inside {PS_PREMASTER, PS_PASSIVE, PS_LISTENING} &&
        tx_class inside {MC_EVENT, MC_ANNOUNCE} |-> !tx_grant)
        else $error("restricted class sent");
    a_uncal_first: assert property (port_r[0] == PS_SLAVE &&
        $past(port_r[0]) != PS_SLAVE |-> $past(port_r[0]) == PS_UNCAL)
        else $error("slave reached without uncalibrated");
    a_gm_cond: assert property (port_r[0] == PS_GRANDMASTER &&
        $past(port_r[0]) == PS_PREMASTER
        |-> $past(mode_r) == MD_AUTO && $past(seen_master_r))
        else $error("grandmaster without cause");
    a_err_status: assert property (|port_error
        |=> port_sync_state == PS_ERROR)
        else $error("error not reported");
    a_status_track: assert property (!(|port_error)
        |=> port_sync_state == port_r[0])
        else $error("status lags the state machine");
    a_servo_na: assert property (!(|is_sync)
        |=> servo_lock_state == SV_NA)
        else $error("servo state applies with no master");
    a_bmi_fill: assert property (1'b1
        |=> best_master_identity[39:24] == EUI_FILL)
        else $error("identity middle not filled");
    a_mode_off: assert property (init_done && !(|is_init) &&
        mode_r == MD_OFF |=> port_r[0] == PS_DISABLED)
        else $error("port active with mode off");
    a_slave_only: assert property (mode_r == MD_SLAVE
        |=> port_r[0] != PS_PREMASTER)
        else $error("slave-only port heading for master");
    a_bvalid_hold: assert property (bvalid && !bready
        |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
endmodule : ptsp_port_state

// ---- ptsp_far_clock.sv ----
// far side clocks: announce, timeout and selection pulses, master address
`timescale 1ns/1ps
module ptsp_far_clock (
    input wire logic aclk,          // bench clock
    output logic [1:0] announce_rx, // announce from a master
    output logic [1:0] announce_tmo, // announce receipt timeout
    output logic [1:0] qual_tmo,    // qualification timeout
    output logic [1:0] bmc_passive, // selection says passive
    output logic [47:0] master_mac  // address of the remote master
);
    initial begin
        {announce_rx, announce_tmo, qual_tmo, bmc_passive} = 8'h00;
        master_mac = 48'h0;
    end

    // one-cycle pulse of kind k on port p; address only moves with announce
    task evt(input int k, input int p, input logic [47:0] mac);
        logic [1:0] b;
        b = 2'h1 << p;
        @(posedge aclk);
        if (k == 0) master_mac <= mac;
        announce_rx <= (k == 0) ? b : 2'h0;
        announce_tmo <= (k == 1) ? b : 2'h0;
        qual_tmo <= (k == 2) ? b : 2'h0;
        bmc_passive <= (k == 3) ? b : 2'h0;
        @(posedge aclk);
        {announce_rx, announce_tmo, qual_tmo, bmc_passive} <= 8'h00;
    endtask : evt
endmodule : ptsp_far_clock

// ---- ptsp_port_state_tb.sv ----
// self-checking bench for the port state block and its register bus
`timescale 1ns/1ps
module ptsp_port_state_tb;
    import ptsp_pkg::*;
    localparam logic [33:0] ALL = 34'h3FFFFFFFF;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, init_done, fault_unconfined;
    logic servo_converging, servo_locked, tx_valid, tx_port, tx_grant;
    logic rx_valid, rx_port, rx_accept;
    logic [AW-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, port_fault, port_error;
    logic [1:0] announce_rx, announce_tmo, qual_tmo, bmc_passive;
    logic [47:0] master_mac, mac, mmac;
    logic [63:0] best_master_identity, id;
    ptsp_msg_t tx_class, rx_class;
    ptsp_port_state_t port_sync_state;
    ptsp_servo_t servo_lock_state;
    logic [33:0] q_exp[$], q_msk[$];
    int mismatches, checked, cyc;

    ptsp_port_state DUT (.*);
    ptsp_far_clock far (.*);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task chk(input logic [33:0] s, input logic [33:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task close_out;
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // one write or read; the answer is noted for the watcher below
    task bus(input bit w, input logic [7:0] a, input logic [31:0] d,
             input logic [33:0] e, input logic [33:0] m);
        logic ah, wh, ar, b;
        @(posedge aclk);
        q_exp.push_back(e);
        q_msk.push_back(m);
        if (w) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        else {araddr, arvalid, rready} <= {a, 2'h3};
        b = 1'b0;
        while (!b) begin
            @(negedge aclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            ar = arvalid & arready;
            b = ((bvalid & bready) | (rvalid & rready)) === 1'b1;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (ar) arvalid <= 1'b0;
        end
        {bready, rready} <= 2'h0;
    endtask : bus

    task st(input logic [15:0] x);
        bus(0, OFS_STATUS, 0, {18'h0, x}, ALL);
    endtask : st

    task gate(input logic p, input logic [5:0] t, input logic [5:0] r);
        for (int c = 0; c < 6; c++) begin
            @(posedge aclk);
            {tx_port, rx_port} <= {p, p};
            tx_class <= ptsp_msg_t'(c);
            rx_class <= ptsp_msg_t'(c);
            @(negedge aclk);
            chk({33'h0, tx_grant}, {33'h0, t[c]});
            chk({33'h0, rx_accept}, {33'h0, r[c]});
        end
        @(posedge aclk);
        {tx_valid, rx_valid} <= 2'h0;
        @(negedge aclk);
        chk({32'h0, tx_grant, rx_accept}, '0);
        @(posedge aclk);
        {tx_valid, rx_valid} <= 2'h3;
    endtask : gate

    always @(posedge aclk) begin
        logic [33:0] s;
        cyc <= cyc + 1;
        s = (bvalid === 1'b1) ? {bresp, 32'h0} : {rresp, rdata};
        if (cyc == 5000) begin
            mismatches++;
            close_out;
        end
        if (((bvalid & bready) | (rvalid & rready)) === 1'b1)
            chk(s & q_msk.pop_front(), q_exp.pop_front());
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
        {wdata, wstrb, init_done, port_fault} = {32'h0, 4'hF, 3'h0};
        {fault_unconfined, port_error, servo_converging, servo_locked} = '0;
        {tx_valid, tx_port, rx_valid, rx_port} = 4'hA;
        tx_class = MC_EVENT;
        rx_class = MC_EVENT;
        {mismatches, checked, cyc} = '0;
        void'($urandom(32'h83EF23C0));
        mac = 48'({$urandom, $urandom});
        mmac = 48'({$urandom, $urandom});
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        st(16'h0030);
        gate(0, 6'h00, 6'h3F);
        bus(1, OFS_MAC_LO, mac[31:0], '0, ALL);
        bus(1, OFS_MAC_HI, {16'h0, mac[47:32]}, '0, ALL);
        id = {mac[47:24], EUI_FILL, mac[23:0]};
        init_done <= 1'b1;
        st(16'h3333);
        bus(0, OFS_BMI_LO, 0, {2'h0, id[31:0]}, ALL);
        bus(0, OFS_BMI_HI, 0, {2'h0, id[63:32]}, ALL);
        gate(0, 6'h1C, 6'h3F);
        servo_converging <= 1'b1;
        far.evt(0, 0, mmac);
        id = {mmac[47:24], EUI_FILL, mmac[23:0]};
        st(16'h3717);
        bus(0, OFS_BMI_HI, 0, {2'h0, id[63:32]}, ALL);
        {servo_locked, servo_converging} <= 2'h2;
        st(16'h3828);
        gate(0, 6'h3F, 6'h3F);
        servo_locked <= 1'b0;
        far.evt(1, 0, mmac);
        far.evt(1, 0, mmac);
        st(16'h3434);
        gate(0, 6'h3C, 6'h3F);
        far.evt(2, 0, mmac);
        st(16'h3939);
        far.evt(3, 0, mmac);
        st(16'h3636);
        gate(0, 6'h1C, 6'h3F);
        port_fault <= 2'h1;
        st(16'h3131);
        gate(0, 6'h10, 6'h3F);
        gate(1, 6'h1C, 6'h3F);
        {port_fault, port_error} <= 4'h1;
        bus(0, OFS_STATUS, 0, 34'hA, 34'h30000000F);
        port_error <= 2'h0;
        bus(1, OFS_CTRL, 32'h21, '0, ALL);
        st(16'h3232);
        gate(0, 6'h00, 6'h30);
        bus(1, OFS_CTRL, 32'h31, '0, ALL);
        fault_unconfined <= 1'b1;
        st(16'h1131);
        fault_unconfined <= 1'b0;
        bus(1, OFS_CTRL, 32'h32, '0, ALL);
        far.evt(1, 0, mmac);
        st(16'h3333);
        bus(0, OFS_CTRL, 0, 34'h32, ALL);
        bus(1, OFS_CTRL, 32'h30, '0, ALL);
        bus(1, OFS_CTRL, 32'h33, '0, ALL);
        bus(0, OFS_CTRL, 0, 34'h30, ALL);
        bus(1, OFS_CTRL, 32'h31, '0, ALL);
        far.evt(1, 0, mmac);
        far.evt(2, 0, mmac);
        st(16'h3535);
        bus(0, 8'h18, 0, {2'h2, 32'h0}, ALL);
        bus(1, 8'h1C, 32'h1, {2'h2, 32'h0}, ALL);
        init_done <= 1'b0;
        st(16'h0030);
        close_out;
    end
endmodule : ptsp_port_state_tb
